/* File: src/sfp_program_ctrl.sv */
// Program and flag-clear command sequencer of a serial NOR flash
`timescale 1ns/1ns
module sfp_program_ctrl #(
    parameter int PAGE = sfp_pkg::PAGE_BYTES,
    parameter int AW = sfp_pkg::ADDR_BITS,
    parameter int BYTE_CYC = sfp_pkg::PROG_BYTE_CYC,
    parameter int TIMEOUT_CYC = sfp_pkg::PROG_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic csn_i,
    input wire logic [3:0] dq_i,
    input wire logic [1:0] protocol_i,
    input wire logic protect_i,
    input wire logic [7:0] array_rdata_i,
    input wire logic array_fail_i,
    output logic [AW-1:0] array_addr_o,
    output logic array_we_o,
    output logic [7:0] array_wdata_o,
    output logic [7:0] status_o,
    output logic [7:0] flag_status_o,
    output logic [15:0] nvcfg_o,
    output logic nvcfg_we_o,
    output logic suspended_o,
    output logic [7:0] read_data_o
);
    localparam int PW = $clog2(PAGE);

    typedef enum {
        SFP_IDLE, SFP_OPCODE, SFP_ADDR, SFP_DATA, SFP_NVDATA, SFP_WAIT_CS,
        SFP_IGNORE
    } sfp_cmd_t;
    typedef enum {
        SFP_P_IDLE, SFP_P_READ, SFP_P_WRITE, SFP_P_NEXT
    } sfp_prog_t;

    sfp_cmd_t cmd_r;
    sfp_prog_t prog_r;
    logic sel;
    logic byte_vld;
    logic [7:0] rx_byte;
    logic aligned;
    logic cs_rise;
    logic [1:0] lines_r;
    logic [7:0] op_r;
    logic [AW-1:0] addr_r;
    logic [1:0] addr_cnt_r;
    logic [PW-1:0] woff_r;
    logic got_data_r;
    logic [15:0] nv_sh_r;
    logic nv_cnt_r;
    logic nv_done_r;
    logic wel_r;
    logic wip_r;
    logic prog_err_r;
    logic prot_err_r;
    logic erase_err_r;
    logic susp_r;
    logic [PW-1:0] poff_r;
    logic [$clog2(BYTE_CYC+1)-1:0] bcnt_r;
    logic [$clog2(TIMEOUT_CYC+1)-1:0] tcnt_r;
    logic [7:0] buf_q;
    logic buf_used;
    logic is_prog;
    logic go_prog;
    logic go_clear;
    logic go_nv;
    logic timeout;
    logic [1:0] op_lines;

    assign is_prog = (op_r == sfp_pkg::OP_PAGE_PROG) ||
                     (op_r == sfp_pkg::OP_DUAL_PROG) ||
                     (op_r == sfp_pkg::OP_XDUAL_PROG) ||
                     (op_r == sfp_pkg::OP_QUAD_PROG) ||
                     (op_r == sfp_pkg::OP_XQUAD_PROG);

    // Opcode width follows protocol; extended ops widen address and data
    assign op_lines = (cmd_r == SFP_OPCODE) ? protocol_i : lines_r;

    sfp_shifter u_shift (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .sck_i(sck_i),
        .csn_i(csn_i),
        .dq_i(dq_i),
        .lines_i(op_lines),
        .sel_o(sel),
        .byte_vld_o(byte_vld),
        .byte_o(rx_byte),
        .aligned_o(aligned),
        .cs_rise_o(cs_rise)
    );

    // Polling frames during a program must not wipe the latched page
    sfp_page_buf #(.PAGE(PAGE), .AW(PW)) u_buf (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(cmd_r == SFP_IDLE && sel && !wip_r),
        .wr_i(cmd_r == SFP_DATA && byte_vld),
        .waddr_i(woff_r),
        .wdata_i(rx_byte),
        .raddr_i(poff_r),
        .rdata_o(buf_q),
        .rvalid_o(buf_used)
    );

    // Program and config writes need a whole final byte and a clean select rise; flag clear needs only the rise
    assign go_prog = cs_rise && cmd_r == SFP_DATA && aligned
                     && got_data_r && is_prog
                     && !wip_r && wel_r && !protect_i;
    assign go_clear = cs_rise && cmd_r == SFP_WAIT_CS
                      && op_r == sfp_pkg::OP_CLR_FLAGS;
    assign go_nv = cs_rise && cmd_r == SFP_NVDATA && nv_done_r && aligned
                   && wel_r && !wip_r;
    // The count holds its last value once idle, so gate by engine state
    assign timeout = (prog_r != SFP_P_IDLE) &&
                     (tcnt_r == ($bits(tcnt_r))'(TIMEOUT_CYC));

    // Command front end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_r <= SFP_IDLE;
            op_r <= 8'h00;
            lines_r <= 2'h0;
            addr_r <= '0;
            addr_cnt_r <= 2'h0;
            woff_r <= '0;
            got_data_r <= 1'b0;
            nv_sh_r <= 16'h0000;
            nv_cnt_r <= 1'b0;
            nv_done_r <= 1'b0;
        end else if (!sel) begin
            cmd_r <= SFP_IDLE;
        end else begin
            unique case (cmd_r)
                SFP_IDLE: begin
                    cmd_r <= SFP_OPCODE;
                    got_data_r <= 1'b0;
                    addr_cnt_r <= 2'h0;
                    nv_cnt_r <= 1'b0;
                    nv_done_r <= 1'b0;
                    lines_r <= protocol_i;
                end
                SFP_OPCODE: if (byte_vld) begin
                    op_r <= rx_byte;
                    if (rx_byte == sfp_pkg::OP_XDUAL_PROG) begin
                        lines_r <= 2'h1;
                    end else if (rx_byte == sfp_pkg::OP_XQUAD_PROG) begin
                        lines_r <= 2'h2;
                    end
                    unique case (rx_byte)
                        sfp_pkg::OP_PAGE_PROG, sfp_pkg::OP_DUAL_PROG,
                        sfp_pkg::OP_XDUAL_PROG, sfp_pkg::OP_QUAD_PROG,
                        sfp_pkg::OP_XQUAD_PROG:
                            cmd_r <= wip_r ? SFP_IGNORE : SFP_ADDR;
                        sfp_pkg::OP_WR_NVCFG: cmd_r <= SFP_NVDATA;
                        sfp_pkg::OP_CLR_FLAGS, sfp_pkg::OP_WREN,
                        sfp_pkg::OP_WRDI, sfp_pkg::OP_SUSPEND,
                        sfp_pkg::OP_RESUME: cmd_r <= SFP_WAIT_CS;
                        default: cmd_r <= SFP_IGNORE;
                    endcase
                end
                SFP_ADDR: if (byte_vld) begin
                    addr_r <= {addr_r[AW-9:0], rx_byte};
                    addr_cnt_r <= addr_cnt_r + 2'h1;
                    if (addr_cnt_r == 2'h2) begin
                        cmd_r <= SFP_DATA;
                        woff_r <= rx_byte[PW-1:0];
                        if (op_r == sfp_pkg::OP_DUAL_PROG) begin
                            lines_r <= 2'h1;
                        end else if (op_r == sfp_pkg::OP_QUAD_PROG) begin
                            lines_r <= 2'h2;
                        end
                    end
                end
                SFP_DATA: if (byte_vld) begin
                    // Offset wraps inside the page; later bytes overwrite
                    woff_r <= woff_r + 1'b1;
                    got_data_r <= 1'b1;
                end
                SFP_NVDATA: if (byte_vld) begin
                    nv_sh_r <= {rx_byte, nv_sh_r[15:8]};
                    nv_cnt_r <= 1'b1;
                    nv_done_r <= nv_cnt_r;
                    // Stay here so select rise can commit; a third byte spoils
                    if (nv_done_r) begin
                        cmd_r <= SFP_IGNORE;
                    end
                end
                SFP_WAIT_CS: if (byte_vld) begin
                    cmd_r <= SFP_IGNORE;
                end
                default: ;
            endcase
        end
    end

    // Byte-by-byte array programming engine
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_r <= SFP_P_IDLE;
            poff_r <= '0;
            bcnt_r <= '0;
            tcnt_r <= '0;
        end else begin
            if (prog_r != SFP_P_IDLE && !susp_r) begin
                tcnt_r <= tcnt_r + 1'b1;
            end
            unique case (prog_r)
                SFP_P_IDLE: if (go_prog) begin
                    prog_r <= SFP_P_READ;
                    poff_r <= '0;
                    tcnt_r <= '0;
                end
                SFP_P_READ: if (timeout) begin
                    prog_r <= SFP_P_IDLE;
                end else if (!susp_r) begin
                    prog_r <= buf_used ? SFP_P_WRITE : SFP_P_NEXT;
                    bcnt_r <= '0;
                end
                SFP_P_WRITE: if (timeout) begin
                    prog_r <= SFP_P_IDLE;
                end else if (!susp_r) begin
                    bcnt_r <= bcnt_r + 1'b1;
                    if (bcnt_r == ($bits(bcnt_r))'(BYTE_CYC - 1)) begin
                        prog_r <= SFP_P_NEXT;
                    end
                end
                SFP_P_NEXT: if (timeout) begin
                    prog_r <= SFP_P_IDLE;
                end else if (!susp_r) begin
                    poff_r <= poff_r + 1'b1;
                    prog_r <= (poff_r == PW'(PAGE - 1)) ? SFP_P_IDLE
                                                         : SFP_P_READ;
                end
            endcase
        end
    end

    assign array_addr_o = {addr_r[AW-1:PW], poff_r};
    // AND with current contents: only ones can become zeros
    assign array_wdata_o = array_rdata_i & buf_q;
    assign array_we_o = (prog_r == SFP_P_WRITE) && !susp_r &&
                        (bcnt_r == ($bits(bcnt_r))'(BYTE_CYC - 1));

    // Busy indication
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wip_r <= 1'b0;
        end else if (go_prog || go_nv) begin
            wip_r <= 1'b1;
        end else if (prog_r == SFP_P_IDLE) begin
            // One cycle past the engine, so the latch clears along with it
            wip_r <= 1'b0;
        end
    end

    // Write enable latch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wel_r <= 1'b0;
        end else if (cs_rise && cmd_r == SFP_WAIT_CS
                     && op_r == sfp_pkg::OP_WREN) begin
            wel_r <= 1'b1;
        end else if (cs_rise && cmd_r == SFP_WAIT_CS
                     && op_r == sfp_pkg::OP_WRDI) begin
            wel_r <= 1'b0;
        end else if (wip_r && prog_r == SFP_P_IDLE && !go_prog) begin
            // Operation over, success or fail
            wel_r <= 1'b0;
        end
    end

    // Error flags; a new error wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_err_r <= 1'b0;
            prot_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end else begin
            if (go_clear) begin
                prog_err_r <= 1'b0;
                prot_err_r <= 1'b0;
                erase_err_r <= 1'b0;
            end
            if (cs_rise && cmd_r == SFP_DATA && aligned && got_data_r
                && wel_r && !wip_r && protect_i) begin
                prog_err_r <= 1'b1;
                prot_err_r <= 1'b1;
            end
            if (timeout || (array_we_o && array_fail_i)) begin
                prog_err_r <= 1'b1;
            end
        end
    end

    // Suspend and resume only matter while a program runs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            susp_r <= 1'b0;
        end else if (cs_rise && cmd_r == SFP_WAIT_CS) begin
            if (op_r == sfp_pkg::OP_SUSPEND && prog_r != SFP_P_IDLE) begin
                susp_r <= 1'b1;
            end else if (op_r == sfp_pkg::OP_RESUME) begin
                susp_r <= 1'b0;
            end
        end else if (prog_r == SFP_P_IDLE) begin
            susp_r <= 1'b0;
        end
    end

    // Nonvolatile configuration store; completes in one cycle here
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nvcfg_o <= sfp_pkg::NVCFG_RESET;
            nvcfg_we_o <= 1'b0;
        end else begin
            nvcfg_we_o <= go_nv;
            if (go_nv) begin
                nvcfg_o <= nv_sh_r;
            end
        end
    end

    assign status_o = {6'h00, wel_r, wip_r};
    assign flag_status_o = {!wip_r, 1'b0, erase_err_r, prog_err_r,
                            2'h0, prot_err_r, 1'b0};
    assign suspended_o = susp_r;

    // Register image for polling, updated every cycle even when busy
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            read_data_o <= 8'h00;
        end else if (op_r == sfp_pkg::OP_RD_FLAGS) begin
            read_data_o <= flag_status_o;
        end else begin
            read_data_o <= status_o;
        end
    end
endmodule : sfp_program_ctrl

/* File: src/sfp_pkg.sv */
// Shared constants for the serial flash program sequencer
package sfp_pkg;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_DUAL_PROG = 8'hA2;
    localparam logic [7:0] OP_XDUAL_PROG = 8'hD2;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_XQUAD_PROG = 8'h38;
    localparam logic [7:0] OP_CLR_FLAGS = 8'h50;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_WR_NVCFG = 8'hB1;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_RD_FLAGS = 8'h70;
    localparam int ADDR_BITS = 24;
    localparam int PAGE_BYTES = 256;
    localparam int NVCFG_BYTES = 2;
    // Status and flag status bit positions
    localparam int FSR_READY = 7;
    localparam int FSR_ERASE_ERR = 5;
    localparam int FSR_PROG_ERR = 4;
    localparam int FSR_PROT_ERR = 1;
    localparam int SR_WEL = 1;
    localparam int SR_WIP = 0;
    localparam logic [7:0] FSR_RESET = 8'h80;
    localparam logic [15:0] NVCFG_RESET = 16'hFFFF;
    // Program timing: cycles per byte written, and a timeout
    localparam int PROG_BYTE_NS = 200;
    localparam int CLK_NS = 40;
    localparam int PROG_BYTE_CYC = (PROG_BYTE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_TIMEOUT_CYC = 65536;
    // Protocol width select
    typedef enum logic [1:0] {
        SFP_LINES_1,
        SFP_LINES_2,
        SFP_LINES_4
    } sfp_lines_t;
endpackage : sfp_pkg

/* File: src/sfp_shifter.sv */
// Serial input shifter: synchronised clock edge detect and byte assembly
`timescale 1ns/1ns
module sfp_shifter (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic csn_i,
    input wire logic [3:0] dq_i,
    input wire logic [1:0] lines_i,
    output logic sel_o,
    output logic byte_vld_o,
    output logic [7:0] byte_o,
    output logic aligned_o,
    output logic cs_rise_o
);
    logic [1:0] sck_s_r;
    logic [1:0] cs_s_r;
    logic [3:0] dq_m_r;
    logic [3:0] dq_s_r;
    logic sck_d_r;
    logic cs_d_r;
    logic [2:0] cnt_r;
    logic [7:0] sh_r;
    logic rise;
    logic [2:0] step;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            dq_m_r <= 4'h0;
            dq_s_r <= 4'h0;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sck_s_r <= {sck_s_r[0], sck_i};
            cs_s_r <= {cs_s_r[0], csn_i};
            dq_m_r <= dq_i;
            dq_s_r <= dq_m_r;
            sck_d_r <= sck_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end

    assign rise = sck_s_r[1] & ~sck_d_r & ~cs_s_r[1];
    assign sel_o = ~cs_s_r[1];
    assign cs_rise_o = cs_s_r[1] & ~cs_d_r;
    assign aligned_o = (cnt_r == 3'h0);
    assign step = (lines_i == 2'h2) ? 3'h4 : (lines_i == 2'h1) ? 3'h2 : 3'h1;

    // Bits sampled on rising serial clock edges only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 3'h0;
            sh_r <= 8'h00;
            byte_vld_o <= 1'b0;
            byte_o <= 8'h00;
        end else begin
            byte_vld_o <= 1'b0;
            if (cs_s_r[1]) begin
                cnt_r <= 3'h0;
            end else if (rise) begin
                unique case (lines_i)
                    2'h2: sh_r <= {sh_r[3:0], dq_s_r};
                    2'h1: sh_r <= {sh_r[5:0], dq_s_r[1:0]};
                    default: sh_r <= {sh_r[6:0], dq_s_r[0]};
                endcase
                cnt_r <= cnt_r + step;
                if (3'(cnt_r + step) == 3'h0) begin
                    byte_vld_o <= 1'b1;
                    unique case (lines_i)
                        2'h2: byte_o <= {sh_r[3:0], dq_s_r};
                        2'h1: byte_o <= {sh_r[5:0], dq_s_r[1:0]};
                        default: byte_o <= {sh_r[6:0], dq_s_r[0]};
                    endcase
                end
            end
        end
    end
endmodule : sfp_shifter

/* File: src/sfp_page_buf.sv */
// Page buffer holding one page of latched program data with byte masks
`timescale 1ns/1ns
module sfp_page_buf #(
    parameter int PAGE = sfp_pkg::PAGE_BYTES,
    parameter int AW = $clog2(sfp_pkg::PAGE_BYTES)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o
);
    logic [7:0] mem_r [PAGE];
    logic [PAGE-1:0] used_r;

    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // A later byte at the same offset replaces the earlier one
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            used_r <= '0;
        end else if (clear_i) begin
            used_r <= '0;
        end else if (wr_i) begin
            used_r[waddr_i] <= 1'b1;
        end
    end

    assign rdata_o = mem_r[raddr_i];
    assign rvalid_o = used_r[raddr_i];
endmodule : sfp_page_buf

/* File: verification/sfp_program_ctrl_monitor.sv */
// Port checker for the program and flag-clear sequencer
`timescale 1ns/1ns
module sfp_program_ctrl_monitor (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic csn_i,
    input wire logic [7:0] status_o,
    input wire logic [7:0] flag_status_o,
    input wire logic [15:0] nvcfg_o,
    input wire logic nvcfg_we_o,
    input wire logic array_we_o,
    input wire logic [7:0] array_wdata_o,
    input wire logic [7:0] array_rdata_i,
    input wire logic suspended_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_prog_end;
        $fell(status_o[0]);
    endsequence
    sequence s_we_gap;
        !array_we_o [*8];
    endsequence
    a_ready_busy: assert property (flag_status_o[7] == !status_o[0])
        else $error("ready flag disagrees with busy bit");
    a_we_busy: assert property (array_we_o |-> status_o[0])
        else $error("array write while not busy");
    a_only_clears: assert property (
        array_we_o |-> (array_wdata_o & ~array_rdata_i) == 8'h00)
        else $error("array write would set a bit");
    a_end_latch: assert property (s_prog_end |-> !status_o[1])
        else $error("latch still set after program end");
    a_start_desel: assert property ($rose(status_o[0]) |-> csn_i)
        else $error("program started while selected");
    a_latch_desel: assert property ($rose(status_o[1]) |-> csn_i)
        else $error("latch set while selected");
    a_clear_desel: assert property ($fell(flag_status_o[4]) |-> csn_i)
        else $error("error flag cleared while selected");
    a_cfg_pulse: assert property ($changed(nvcfg_o) |-> ##[0:2] nvcfg_we_o)
        else $error("config change without update pulse");
    a_susp_busy: assert property (suspended_o |-> status_o[0])
        else $error("suspended without a running program");
    a_we_spacing: assert property (array_we_o |=> s_we_gap)
        else $error("array writes closer than byte time");
endmodule : sfp_program_ctrl_monitor
bind sfp_program_ctrl sfp_program_ctrl_monitor u_mon (.clk_i(clk_i),
    .resetn_i(resetn_i), .csn_i(csn_i), .status_o(status_o),
    .flag_status_o(flag_status_o), .nvcfg_o(nvcfg_o),
    .nvcfg_we_o(nvcfg_we_o), .array_we_o(array_we_o),
    .array_wdata_o(array_wdata_o), .array_rdata_i(array_rdata_i),
    .suspended_o(suspended_o));

/* File: verification/sfp_host_model.sv */
// Host controller model driving select, serial clock and data lines
`timescale 1ns/1ns
module sfp_host_model (
    input wire logic clk_i,
    output logic sck_o,
    output logic csn_o,
    output logic [3:0] dq_o
);
    initial begin
        sck_o = 1'b0;
        csn_o = 1'b1;
        dq_o = 4'h0;
    end
    // Bytes go MSB first; lo/la/ld lines for opcode, address, data bytes
    task automatic frame(input logic [7:0] b[$], input int lo, input int la,
                         input int ld, input int cut);
        int n;
        @(negedge clk_i);
        csn_o = 1'b0;
        for (int i = 0; i < b.size(); i++) begin
            n = (i == 0) ? lo : ((i < 4) ? la : ld);
            for (int k = 8 - n; k >= 0; k -= n) begin
                // A cut drops trailing bits of the last byte
                if (i == b.size() - 1 && k < cut) break;
                dq_o = 4'((b[i] >> k) & ((1 << n) - 1));
                repeat (4) @(negedge clk_i);
                sck_o = 1'b1;
                repeat (4) @(negedge clk_i);
                sck_o = 1'b0;
            end
        end
        repeat (2) @(negedge clk_i);
        csn_o = 1'b1;
        // Released lines must not keep showing the last bit
        dq_o = ~dq_o;
        repeat (6) @(negedge clk_i);
    endtask : frame
endmodule : sfp_host_model

/* File: verification/serial_flash_page_program_control_tb.sv */
// Self-checking bench for the program and flag-clear sequencer
`timescale 1ns/1ns
module serial_flash_page_program_control_tb;
    logic clk_i, resetn_i, sck_i, csn_i, protect_i, array_fail_i;
    logic [3:0] dq_i;
    logic [1:0] protocol_i;
    logic [7:0] array_rdata_i, array_wdata_o, status_o, flag_status_o;
    logic [7:0] read_data_o;
    logic [23:0] array_addr_o;
    logic array_we_o, nvcfg_we_o, suspended_o;
    logic [15:0] nvcfg_o;
    logic [7:0] mem [0:1023];
    logic [7:0] ops [5] = '{8'h02, 8'hA2, 8'hD2, 8'h32, 8'h38};
    int las [5] = '{1, 1, 2, 1, 4};
    int lds [5] = '{1, 2, 2, 4, 4};
    int err_count = 0;
    int cmp_count = 0;
    int b;
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    sfp_host_model u_host (.clk_i(clk_i), .sck_o(sck_i), .csn_o(csn_i),
        .dq_o(dq_i));
    // Small page and long byte time so suspend lands mid-program
    sfp_program_ctrl #(.PAGE(16), .BYTE_CYC(20), .TIMEOUT_CYC(2000)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck_i), .csn_i(csn_i),
        .dq_i(dq_i), .protocol_i(protocol_i), .protect_i(protect_i),
        .array_rdata_i(array_rdata_i), .array_fail_i(array_fail_i),
        .array_addr_o(array_addr_o), .array_we_o(array_we_o),
        .array_wdata_o(array_wdata_o), .status_o(status_o),
        .flag_status_o(flag_status_o), .nvcfg_o(nvcfg_o),
        .nvcfg_we_o(nvcfg_we_o), .suspended_o(suspended_o),
        .read_data_o(read_data_o));
    assign array_rdata_i = mem[array_addr_o[9:0]];
    always @(posedge clk_i) begin
        if (array_we_o) mem[array_addr_o[9:0]] <= array_wdata_o;
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8
    task automatic wait_wip(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && status_o[0] !== v; i++) @(negedge clk_i);
        if (i == lim) begin
            err_count++;
            $display("Error at %0t: busy bit wait ran out", $time);
            final_report();
        end
    endtask : wait_wip
    task automatic cmd(input logic [7:0] q[$]);
        int l;
        l = 1 << protocol_i;
        u_host.frame(q, l, l, l, 0);
    endtask : cmd
    task automatic prog(input logic [7:0] op, input int lo, input int la,
                        input int ld, input int a, input int n, input int cut);
        logic [7:0] q[$];
        q = '{op, 8'(a >> 16), 8'(a >> 8), 8'(a)};
        for (int i = 0; i < n; i++) q.push_back(8'hF0 + 8'(i));
        u_host.frame(q, lo, la, ld, cut);
    endtask : prog
    initial begin
        resetn_i = 1'b0;
        protocol_i = 2'h0;
        protect_i = 1'b0;
        array_fail_i = 1'b0;
        for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk8(status_o, 8'h00);
        chk8(flag_status_o, 8'h80);
        chk8(nvcfg_o[7:0], 8'hFF);
        prog(sfp_pkg::OP_PAGE_PROG, 1, 1, 1, 'h10, 1, 0);
        chk8(status_o, 8'h00);
        chk8(mem['h10], 8'hFF);
        cmd('{sfp_pkg::OP_WREN});
        chk8(status_o, 8'h02);
        prog(sfp_pkg::OP_PAGE_PROG, 1, 1, 1, 'h10, 2, 3);
        chk8(status_o, 8'h02);
        chk8(flag_status_o, 8'h80);
        chk8(mem['h10], 8'hFF);
        for (int p = 0; p < 3; p++) begin
            protocol_i = 2'(p);
            protect_i = 1'b1;
            b = 1 << p;
            prog(sfp_pkg::OP_PAGE_PROG, b, b, b, 'h20, 1, 0);
            chk8(flag_status_o, 8'h92);
            chk8(status_o, 8'h02);
            protect_i = 1'b0;
            cmd('{sfp_pkg::OP_CLR_FLAGS});
            chk8(flag_status_o, 8'h80);
        end
        protocol_i = 2'h0;
        for (int i = 0; i < 5; i++) begin
            b = 32 * (i + 1);
            mem[b] = 8'h0F;
            cmd('{sfp_pkg::OP_WREN});
            prog(ops[i], 1, las[i], lds[i], b + 14, 3, 0);
            wait_wip(1'b1, 100);
            chk8(flag_status_o, 8'h00);
            wait_wip(1'b0, 1000);
            chk8(status_o, 8'h00);
            chk8(flag_status_o, 8'h80);
            chk8(mem[b + 14], 8'hF0);
            chk8(mem[b + 15], 8'hF1);
            chk8(mem[b], 8'h02);
            chk8(mem[b + 1], 8'hFF);
        end
        cmd('{sfp_pkg::OP_WREN});
        prog(sfp_pkg::OP_PAGE_PROG, 1, 1, 1, 'h300, 18, 0);
        wait_wip(1'b1, 100);
        wait_wip(1'b0, 1000);
        chk8(mem['h300], 8'h00);
        chk8(mem['h301], 8'h01);
        chk8(mem['h302], 8'hF2);
        cmd('{sfp_pkg::OP_WREN});
        prog(sfp_pkg::OP_PAGE_PROG, 1, 1, 1, 'h340, 16, 0);
        wait_wip(1'b1, 100);
        cmd('{sfp_pkg::OP_RD_FLAGS});
        chk8(read_data_o, 8'h00);
        cmd('{sfp_pkg::OP_SUSPEND});
        chk8({7'h00, suspended_o}, 8'h01);
        chk8(status_o, 8'h03);
        cmd('{sfp_pkg::OP_RESUME});
        chk8({7'h00, suspended_o}, 8'h00);
        wait_wip(1'b0, 1000);
        chk8(mem['h340], 8'hF0);
        array_fail_i = 1'b1;
        cmd('{sfp_pkg::OP_WREN});
        prog(sfp_pkg::OP_PAGE_PROG, 1, 1, 1, 'h380, 1, 0);
        wait_wip(1'b1, 100);
        wait_wip(1'b0, 1000);
        chk8(flag_status_o, 8'h90);
        chk8(status_o, 8'h00);
        array_fail_i = 1'b0;
        cmd('{sfp_pkg::OP_CLR_FLAGS});
        chk8(flag_status_o, 8'h80);
        cmd('{sfp_pkg::OP_WREN});
        cmd('{sfp_pkg::OP_WR_NVCFG, 8'h34, 8'h12});
        wait_wip(1'b0, 1000);
        chk8(nvcfg_o[7:0], 8'h34);
        chk8(nvcfg_o[15:8], 8'h12);
        final_report();
    end
endmodule : serial_flash_page_program_control_tb
